//--- rtl/arsc_pkg.sv
// package: constants and carriers for the converter result and sleep control
package arsc_pkg;

  // ==========================================================
  // reference selection codes
  localparam logic [1:0] REF_EXT_PIN   = 2'h0; // external reference pin
  localparam logic [1:0] REF_SUPPLY    = 2'h1; // analog supply
  localparam logic [1:0] REF_INT_1V1   = 2'h2; // internal 1.1 V
  localparam logic [1:0] REF_INT_2V56  = 2'h3; // internal 2.56 V
  localparam logic [1:0] RST_REF_SEL   = 2'h0;

  // ==========================================================
  // result codes and field positions
  localparam int         RES_W         = 10;
  localparam logic [9:0] CODE_ZERO     = 10'h000;
  localparam logic [9:0] CODE_FULL     = 10'h3ff;
  localparam logic [9:0] CODE_DIFF_MIN = 10'h200;
  localparam logic [9:0] CODE_DIFF_MAX = 10'h1ff;
  localparam int         SIGN_POS      = 9;
  localparam logic [9:0] RST_RESULT    = 10'h000;

  // ==========================================================
  // conversion timing, in converter clock ticks
  localparam int         CONV_TICKS    = 13;
  localparam int         FIRST_TICKS   = 25;
  localparam logic [7:0] RST_PRESCALE  = 8'h01;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } arsc_state_t;

  // sample taken at conversion start
  typedef struct packed {
    logic       diff;      // differential conversion
    logic [1:0] refSel;    // latched reference
    logic [9:0] sample;    // raw analog code from comparator array
  } arsc_conv_t;

endpackage

//--- rtl/arsc_adc_ctrl.sv
// result formatting and sleep-triggered conversion control of the converter
`timescale 1ns/1ns
`default_nettype none

module arsc_adc_ctrl
  import arsc_pkg::*;
#(
  parameter int PRESCALE = 2 // system clocks per converter clock tick, at least 1
) (
  input  wire logic       mclk,              // system clock, 25 MHz
  input  wire logic       sys_rst,           // synchronous reset, active high
  input  wire logic       converter_enable,  // converter on
  input  wire logic       conversion_start,  // one-cycle start request
  input  wire logic       result_left_align, // left-adjust presentation
  input  wire logic [1:0] reference_select,  // requested reference
  input  wire logic       diffMode,          // selected channel pair is differential
  input  wire logic [4:0] posChannel,        // positive input channel
  input  wire logic [4:0] negChannel,        // negative input channel, may equal positive
  input  wire logic       cpuHalted,         // cpu has halted in sleep
  input  wire logic       sleepNoiseIdle,    // sleep mode is noise reduction or idle
  input  wire logic       irqEnable,         // completion interrupt enabled
  input  wire logic       irqAck,            // interrupt serviced
  input  wire logic       flagClear,         // software clears done flag
  input  wire logic       otherWake,         // another interrupt woke the cpu
  input  wire logic [10:0] analogCode,       // comparator code, bit 10 = over range
  output logic            conversion_done_flag, // sticky done flag
  output logic            convBusy,          // conversion running
  output logic            irqRequest,        // completion interrupt request
  output logic            cpuWake,           // wake pulse to cpu
  output logic [1:0]      activeRef,         // reference in use by analog side
  output logic [4:0]      muxPos,            // positive mux drive
  output logic [4:0]      muxNeg,            // negative mux drive
  output logic [7:0]      result_low_byte,   // low result byte
  output logic [7:0]      result_high_byte   // high result byte
);

  // ==========================================================
  // overview
  // a conversion runs in three steps: a start is queued, the queue is
  // taken on the next converter tick in idle, and the sample and the
  // reference are latched for the whole conversion.
  // completion stores the code, sets the done flag and, when the
  // conversion came from a sleep entry with the cpu still halted and no
  // other wake seen, sends one wake pulse.
  // the analog side only ever sees registered selections, so a write to
  // the selects during a conversion cannot disturb the sampling window.
  // limitation: only single conversions are served, there is no
  // free-running start; the only automatic start is the one queued on a sleep halt.

  // ==========================================================
  // elaboration checks
  // the prescaler counter is eight bits wide, longer periods cannot be served
  if (PRESCALE < 1 || PRESCALE > 255) begin : g_bad_prescale
    $error("prescale out of range");
  end
  // the tick counter is five bits wide; a longer first conversion would wrap
  if (FIRST_TICKS > 32 || CONV_TICKS < 1 || CONV_TICKS > FIRST_TICKS) begin : g_bad_ticks
    $error("conversion tick counts out of range");
  end

  // ==========================================================
  // prescaler: held in reset while converter is off
  // one tick every PRESCALE system clocks; starting from its reset value
  // puts the first tick after enable a full period later
  logic [7:0] preCnt, next_preCnt;
  logic       tick;

  always_comb begin
    next_preCnt = preCnt;
    tick        = 1'b0;
    if (!converter_enable) begin
      next_preCnt = RST_PRESCALE;
    end else if (preCnt >= 8'(PRESCALE)) begin
      next_preCnt = RST_PRESCALE;
      tick        = 1'b1;
    end else begin
      next_preCnt = preCnt + 8'h01;
    end
  end

  // prescaler register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      preCnt <= RST_PRESCALE;
    end else begin
      preCnt <= next_preCnt;
    end
  end

  // ==========================================================
  // conversion sequencer
  arsc_state_t state, next_state;
  logic [4:0]  tickCnt, next_tickCnt;
  logic        firstConv, next_firstConv;
  logic        startPend, next_startPend;
  logic        sleepArmed, next_sleepArmed;
  logic        sleepConv, next_sleepConv;
  logic        doneNow;
  // one record per conversion, latched at start
  arsc_conv_t  conv, next_conv;
  logic [9:0]  stored, next_stored;
  logic [9:0]  rawCode;

  always_comb begin
    if (!diffMode && analogCode[10]) begin
      rawCode = CODE_FULL;
    end else begin
      // differential codes pass untouched, the sign already sits in bit 9
      rawCode = analogCode[9:0];
    end
  end

  // sequencer next state; a start that arrives while busy stays queued
  always_comb begin
    next_state      = state;
    next_tickCnt    = tickCnt;
    next_firstConv  = firstConv;
    next_startPend  = startPend | conversion_start;
    next_sleepArmed = sleepArmed;
    next_sleepConv  = sleepConv;
    next_conv       = conv;
    next_stored     = stored;
    doneNow         = 1'b0;
    // re-arm only while the cpu is not halted
    // armed again only once the cpu runs, so one halt gives one start
    if (!cpuHalted) begin
      next_sleepArmed = 1'b1;
    end
    case (state)
      ST_OFF: begin
        // off: forget queued starts, the next conversion is the long one
        next_firstConv = 1'b1;
        next_startPend = 1'b0;
        if (converter_enable) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // a halt with the sleep conditions queues exactly one start
        // auto start on halt in noise-reduction or idle
        if (cpuHalted && sleepNoiseIdle && sleepArmed && irqEnable) begin
          next_startPend  = 1'b1;
          next_sleepArmed = 1'b0;
          next_sleepConv  = 1'b1;
        end
        if (startPend && tick) begin
          next_state     = ST_CONV;
          next_startPend = 1'b0;
          next_tickCnt   = 5'h00;
          // lock reference and channels at start
          next_conv.diff   = diffMode;
          next_conv.refSel = reference_select;
          next_conv.sample = rawCode;
        end
      end
      ST_CONV: begin
        // the first conversion after enable is long to settle the analog side
        if (tick) begin
          next_tickCnt = tickCnt + 5'h01;
          if (tickCnt == 5'((firstConv ? FIRST_TICKS : CONV_TICKS) - 1)) begin
            doneNow        = 1'b1;
            next_firstConv = 1'b0;
            next_state     = ST_IDLE;
            next_stored    = conv.sample;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // only clearing the enable stops the converter
    // any sleep mode leaves the converter running unless software clears it
    if (!converter_enable) begin
      next_state     = ST_OFF;
      next_sleepConv = 1'b0;
    end
  end

  // sequencer registers; the sleep marker drops with completion
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state      <= ST_OFF;
      tickCnt    <= 5'h00;
      firstConv  <= 1'b1;
      startPend  <= 1'b0;
      sleepArmed <= 1'b1;
      sleepConv  <= 1'b0;
      conv       <= '0;
      stored     <= RST_RESULT;
    end else begin
      state      <= next_state;
      tickCnt    <= next_tickCnt;
      firstConv  <= next_firstConv;
      startPend  <= next_startPend;
      sleepArmed <= next_sleepArmed;
      sleepConv  <= doneNow ? 1'b0 : next_sleepConv;
      conv       <= next_conv;
      stored     <= next_stored;
    end
  end

  // ==========================================================
  // done flag, interrupt request, wake
  logic next_flag, next_irq, next_wake;

  // a completion landing on the clear cycle must not be lost, so the
  // set term wins; the cost is that such a clear has to be repeated
  // acknowledge and clear act alike, the cpu may use either
  always_comb begin
    // set wins over clear or acknowledge
    next_flag = doneNow | (conversion_done_flag & ~flagClear & ~irqAck);
    // request raised even if cpu woke earlier
    next_irq  = next_flag & irqEnable;
    // completion of sleep conversion wakes cpu
    next_wake = doneNow & sleepConv & ~otherWake & cpuHalted;
  end

  // all three outputs are registered so the cpu sees clean levels
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conversion_done_flag <= 1'b0;
      irqRequest           <= 1'b0;
      cpuWake              <= 1'b0;
    end else begin
      conversion_done_flag <= next_flag;
      irqRequest           <= next_irq;
      cpuWake              <= next_wake;
    end
  end

  // ==========================================================
  // analog side drive and result presentation
  logic [1:0] next_ref;
  logic [4:0] next_pos, next_neg;
  logic [7:0] next_low, next_high;

  // mux drive copies its own registered value while converting, so the
  // channel seen at the sampling point cannot move under the comparator
  always_comb begin
    // reference follows request only when not converting
    next_ref = (next_state == ST_CONV) ? next_conv.refSel : reference_select;
    next_pos = (next_state == ST_CONV) ? muxPos : posChannel;
    next_neg = (next_state == ST_CONV) ? muxNeg : negChannel;
    // differential codes kept as two's complement, bit 9 is sign; single-ended codes are unsigned
    // alignment applied to the stored value every cycle
    if (result_left_align) begin
      next_high = next_stored[9:2];
      next_low  = {next_stored[1:0], 6'h00};
    end else begin
      next_high = {6'h00, next_stored[9:8]};
      next_low  = next_stored[7:0];
    end
  end

  // presentation registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      activeRef        <= RST_REF_SEL;
      muxPos           <= 5'h00;
      muxNeg           <= 5'h00;
      result_low_byte  <= 8'h00;
      result_high_byte <= 8'h00;
      convBusy         <= 1'b0;
    end else begin
      activeRef        <= next_ref;
      muxPos           <= next_pos;
      muxNeg           <= next_neg;
      result_low_byte  <= next_low;
      result_high_byte <= next_high;
      convBusy         <= (next_state == ST_CONV);
    end
  end

endmodule

`default_nettype wire

//--- test/arsc_analog_model.sv
// analog side model: sampled codes from channel and reference
`timescale 1ns/1ns
`default_nettype none
module arsc_analog_model (
  input  wire logic [1:0]  activeRef, // reference in use
  input  wire logic [4:0]  muxPos,    // positive channel
  input  wire logic [4:0]  muxNeg,    // negative channel
  input  wire logic        diffMode,  // pair mode
  output logic      [10:0] analogCode // sampled code
);
  // ==========================================================
  // channel 31 sits above any reference; pairs give (pos-neg)*32
  always_comb begin
    if (diffMode) analogCode = {1'b0, muxPos - muxNeg, 5'h00};
    else analogCode = {muxPos == 5'h1f, muxPos, activeRef, 3'h5};
  end
endmodule
`default_nettype wire

//--- test/arsc_adc_ctrl_sva.sv
// checker for the converter result and sleep control ports
`timescale 1ns/1ns
`default_nettype none
module arsc_adc_ctrl_sva #(
  parameter int PRESCALE = 2 // converter clock divider, kept for the bind
) (
  input wire logic       mclk,                 // system clock
  input wire logic       sys_rst,              // synchronous reset, active high
  input wire logic       converter_enable,     // converter on
  input wire logic       result_left_align,    // left-adjust presentation
  input wire logic       cpuHalted,            // cpu halted in sleep
  input wire logic       sleepNoiseIdle,       // sleep mode allows auto start
  input wire logic       irqEnable,            // completion interrupt enabled
  input wire logic       irqAck,               // interrupt serviced
  input wire logic       flagClear,            // done flag cleared
  input wire logic       conversion_done_flag, // done flag
  input wire logic       convBusy,             // conversion running
  input wire logic       irqRequest,           // interrupt request
  input wire logic       cpuWake,              // wake pulse
  input wire logic [1:0] reference_select,     // requested reference
  input wire logic [1:0] activeRef,            // reference in use
  input wire logic [4:0] muxPos,               // positive mux
  input wire logic [7:0] result_low_byte,      // low result byte
  input wire logic [7:0] result_high_byte      // high result byte
);
  // ==========================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_right_pad: assert property (!result_left_align [*3] |-> result_high_byte[7:2] == 6'h00)
    else $error("right adjusted high byte not padded");
  a_left_pad: assert property (result_left_align [*3] |-> result_low_byte[5:0] == 6'h00)
    else $error("left adjusted low byte not padded");
  a_align_switch: assert property ($rose(result_left_align) && !convBusy |=> ##1
    {result_high_byte, result_low_byte[7:6]} == $past({result_high_byte[1:0], result_low_byte}, 2))
    else $error("align change did not re-present result");
  a_result_hold: assert property ((!convBusy && $stable(result_left_align)) [*2]
    |=> $stable({result_high_byte, result_low_byte}))
    else $error("result bytes changed without completion");
  a_flag_hold: assert property (conversion_done_flag && converter_enable && !irqAck && !flagClear
    |=> conversion_done_flag)
    else $error("done flag dropped without clear");
  a_irq_raise: assert property (conversion_done_flag && irqEnable && !irqAck && !flagClear |=> irqRequest)
    else $error("interrupt request missing while flag set");
  a_wake_pulse: assert property (cpuWake |-> conversion_done_flag && $past(cpuHalted) ##1 !cpuWake)
    else $error("wake pulse without completion");
  a_sleep_start: assert property ($rose(cpuHalted) && sleepNoiseIdle && irqEnable
    && converter_enable && !convBusy |-> ##[1:8] convBusy)
    else $error("no conversion after halt");
  a_ref_lock: assert property (convBusy && $past(convBusy) |-> $stable(activeRef) && $stable(muxPos))
    else $error("selection moved during conversion");
  a_ref_follow: assert property ((converter_enable && !convBusy && $stable(reference_select)) [*3]
    |-> activeRef == reference_select)
    else $error("idle reference not following select");
endmodule
bind arsc_adc_ctrl arsc_adc_ctrl_sva #(.PRESCALE(PRESCALE)) arsc_adc_ctrl_sva_inst (.*);
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the converter result and sleep control
`timescale 1ns/1ns
`default_nettype none
module tb;
  import arsc_pkg::*;
  typedef struct packed {
    logic       diff; logic [4:0] pos, neg; logic [1:0] rsel; logic left; logic [7:0] hi, lo;
  } arsc_row_t;
  logic        mclk = 0, sys_rst = 1, converter_enable = 0, conversion_start = 0, result_left_align = 0;
  logic        diffMode = 0, cpuHalted = 0, sleepNoiseIdle = 0, irqEnable = 0, irqAck = 0;
  logic        flagClear = 0, otherWake = 0, conversion_done_flag, convBusy, irqRequest, cpuWake;
  logic [1:0]  reference_select = 0, activeRef;
  logic [4:0]  posChannel = 0, negChannel = 0, muxPos, muxNeg;
  logic [10:0] analogCode;
  logic [7:0]  result_low_byte, result_high_byte;
  int          n_fail = 0, check_count = 0;
  localparam int TB_PRESCALE = 1;
  logic [7:0]  busyRun = 0; // cycles the running conversion has been busy, held one cycle after it ends, then cleared
  // single-ended, over-range, differential and same-channel cases
  arsc_row_t   rows [7] = '{'{0, 3, 0, 1, 0, 'h00, 'h6d}, '{0, 3, 0, 2, 1, 'h1d, 'h40},
    '{0, 31, 0, 3, 0, 'h03, 'hff}, '{1, 2, 5, 3, 0, 'h03, 'ha0}, '{1, 4, 4, 0, 1, 'h00, 'h00},
    '{1, 5, 2, 1, 1, 'h18, 'h00}, '{0, 1, 0, 0, 0, 'h00, 'h25}};
  arsc_adc_ctrl #(.PRESCALE(TB_PRESCALE)) arsc_adc_ctrl_inst (.*);
  arsc_analog_model arsc_analog_model_inst (.*);
  always #20 mclk = ~mclk;
  // length of the running or just finished conversion in system clocks
  always @(posedge mclk) busyRun <= convBusy ? busyRun + 8'h01 : 8'h00;
  // ==========================================================
  // helpers: inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (conversion_done_flag !== 1'b1 && k < 300) begin
      step(1);
      k++;
    end
    if (conversion_done_flag !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic convert();
    conversion_start = 1; step(1); conversion_start = 0;
    wait_done();
  endtask
  task automatic clear();
    flagClear = 1; step(1); flagClear = 0; step(1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    step(6); sys_rst = 0;
    chk(result_high_byte, 0); chk(conversion_done_flag, 0);
    converter_enable = 1;
    foreach (rows[i]) begin
      diffMode = rows[i].diff; posChannel = rows[i].pos; negChannel = rows[i].neg;
      reference_select = rows[i].rsel; result_left_align = rows[i].left;
      step(3); convert();
      chk(result_high_byte, rows[i].hi);
      chk(result_low_byte, rows[i].lo);
      chk(activeRef, rows[i].rsel);
      chk(busyRun, 8'((i == 0 ? FIRST_TICKS : CONV_TICKS) * TB_PRESCALE));
      clear();
    end
    result_left_align = 1; step(2);
    chk(result_high_byte, 8'h09); chk(result_low_byte, 8'h40);
    result_left_align = 0; posChannel = 3; reference_select = 1; step(3);
    conversion_start = 1; step(1); conversion_start = 0; step(2); reference_select = 2;
    wait_done(); chk(result_low_byte, 8'h6d); clear();
    chk(activeRef, 2'h2);
    // first result after the switch is thrown away
    convert(); clear();
    // toggle enable so the next conversion is a long one
    converter_enable = 0; step(1); converter_enable = 1; step(2);
    // enabled, idle, single mode, interrupt on before sleeping
    irqEnable = 1; sleepNoiseIdle = 1; cpuHalted = 1;
    wait_done(); chk(busyRun, 8'(FIRST_TICKS * TB_PRESCALE));
    chk(cpuWake, 1); step(1); chk(irqRequest, 1);
    step(20); chk(irqRequest, 1); chk(convBusy, 0);
    irqAck = 1; step(1); irqAck = 0; step(1); chk(irqRequest, 0);
    cpuHalted = 0; step(2); cpuHalted = 1; otherWake = 1;
    wait_done(); chk(cpuWake, 0); step(1); chk(irqRequest, 1);
    cpuHalted = 0; otherWake = 0; irqEnable = 0; sys_rst = 1; step(2); sys_rst = 0; step(1);
    chk(result_low_byte, 0); chk(conversion_done_flag, 0); chk(irqRequest, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
